// >>> src/pdsc_pkg.sv
package pdsc_pkg;
   // Status word bit positions
   localparam int ST_REACHED  = 0;
   localparam int ST_TOGGLE   = 2;
   localparam int ST_POWER    = 4;
   localparam int ST_ABORT    = 5;
   localparam int ST_RUNNING  = 6;
   localparam int ST_TEMP     = 7;
   localparam int ST_OPPOSITE = 8;
   localparam int ST_FAULT    = 9;
   localparam int ST_BLOCK    = 10;
   localparam int ST_DISPL    = 11;
   localparam int ST_BADTGT   = 12;
   localparam int ST_NOPOWER  = 13;
   localparam int ST_LIM_FWD  = 14;
   localparam int ST_LIM_REV  = 15;

   // Only the opposite-loop flag is up after power-up or a reset command
   localparam logic [15:0] STATUS_RESET   = 16'h0100;
   // Bits 5, 10, 11, 12 and 13
   localparam logic [15:0] ACK_CLEAR_MASK = 16'h3C20;
   // 30 V upper supply bound, in millivolts
   localparam logic [15:0] MOTOR_MAX_MV   = 16'h7530;
   // Over-temperature release hysteresis, degrees C
   localparam logic signed [15:0] TEMP_HYST_C = 16'sh0005;

   localparam int STEPS_PER_REV_DEF = 400;
   // Loop reversal is 5/8 of one rotation
   localparam int LOOP_NUM          = 5;
   localparam int LOOP_DEN          = 8;
   // Second positioning above 0.9 degrees, in millidegrees
   localparam int DEV_MDEG          = 900;
   localparam int MDEG_PER_REV      = 360000;

   typedef enum logic [5:0] {
      S_IDLE     = 6'h01,
      S_MANUAL   = 6'h02,
      S_LOOP     = 6'h04,
      S_APPROACH = 6'h08,
      S_CHECK    = 6'h10,
      S_SECOND   = 6'h20
   } pdsc_state_t;

   // Command word, bit 15 first
   typedef struct packed {
      logic       rsv15;
      logic       err_ack;
      logic       toggle;
      logic [2:0] rsv12;
      logic [1:0] param_set;
      logic       rsv7;
      logic       no_loop;
      logic       rsv5;
      logic       release_run;
      logic       rsv3;
      logic       take_target;
      logic       man_rev;
      logic       man_fwd;
   } pdsc_cmd_t;

   typedef struct packed {
      logic        [15:0] motor_mv;
      logic        [15:0] umin_mv;
      logic signed [15:0] temp_c;
      logic signed [15:0] temp_limit_c;
   } pdsc_sense_t;

   typedef struct packed {
      logic signed [31:0] upper;
      logic signed [31:0] lower;
      logic signed [31:0] window;
      logic signed [31:0] loop_len;
      logic        [15:0] speed_max;
   } pdsc_cfg_t;

   typedef struct packed {
      logic signed [31:0] goal;
      logic               fwd;
      logic               manual;
      logic               req;
   } pdsc_move_t;

   typedef struct packed {
      pdsc_state_t        state;
      logic        [15:0] status;
      logic signed [31:0] target;
      pdsc_cmd_t          cmd_last;
      logic        [1:0]  param_set;
      logic               second;
      logic               refloop;
      logic               completed;
      pdsc_move_t         move;
      logic        [15:0] rpm;
      logic signed [31:0] pos;
   } pdsc_regs_t;
endpackage

// >>> src/pdsc_drive_ctrl.sv
// What this block does
// - Target-reached flag set on arrival, cleared otherwise
// - Copy command bit 13 into status bit 2
// - Status bit 4 shows motor supply in range
// - Positioning abort by release loss sets bit 5
// - Over-temperature flag with 5 C hysteresis
// - Opposite-loop flag after reset or reverse motion
// - Fault bit sticky until reset, blocks runs
// - Overload abort sets bit 10
// - External turn at standstill sets bit 11
// - Invalid target or speed sets bit 12
// - Motor voltage missing at positioning start sets bit 13
// - Limit bits follow position beyond limits
// - Bit 2 accepts target, else last target
// - Runs only with release; withdrawal aborts
// - Bit 6 forces direct approach without loop
// - Bits 9..8 select parameter set
// - Acknowledge rising edge clears error bits
// - Reverse target gets 5/8 rotation loop
// - Second positioning once, then window check
// - Input data: status, speed, position
// - Output data: command, target, optional speed
`timescale 1ns/1ps
module pdsc_drive_ctrl #(
   parameter int STEPS_PER_REV = pdsc_pkg::STEPS_PER_REV_DEF
) (
   input  wire logic               clk_i,
   input  wire logic               sys_rst_i,
   input  wire logic               clk_en_i,
   input  wire logic               telegram_i,
   input  wire pdsc_pkg::pdsc_cmd_t cmd_i,
   input  wire logic signed [31:0] target_pos_i,
   input  wire logic        [15:0] target_speed_i,
   input  wire logic               speed_in_pd_i,
   input  wire pdsc_pkg::pdsc_sense_t sense_i,
   input  wire pdsc_pkg::pdsc_cfg_t cfg_i,
   input  wire logic signed [31:0] actual_pos_i,
   input  wire logic        [15:0] actual_rpm_i,
   input  wire logic               running_i,
   input  wire logic               move_done_i,
   input  wire logic               overload_i,
   input  wire logic               flash_fault_i,
   input  wire logic               calc_fault_i,
   input  wire logic               reset_cmd_i,
   input  wire logic               readjust_en_i,
   output logic             [15:0] status_word_o,
   output logic             [63:0] pd_in_o,
   output logic              [1:0] param_set_o,
   output pdsc_pkg::pdsc_move_t    move_o
);
   localparam logic signed [31:0] LOOP_STEPS =
      32'(STEPS_PER_REV * pdsc_pkg::LOOP_NUM / pdsc_pkg::LOOP_DEN);
   localparam logic [31:0] DEV_STEPS =
      32'(STEPS_PER_REV * pdsc_pkg::DEV_MDEG / pdsc_pkg::MDEG_PER_REV);

   pdsc_pkg::pdsc_regs_t st;
   pdsc_pkg::pdsc_regs_t next_st;
   pdsc_pkg::pdsc_cmd_t  cur;
   logic               vok;
   logic               loop_on;
   logic               loop_fwd;
   logic               ack_rise;
   logic               rel_rise;
   logic               idle;
   logic               fault;
   logic               speed_bad;
   logic               tgt_ok;
   logic               start_man;
   logic               start_pos;
   logic               displaced;
   logic               readjust;
   logic               go;
   logic signed [31:0] go_t;
   logic               go_loop;
   logic        [31:0] dev;
   logic        [15:0] set_v;
   logic        [15:0] clr_v;

   function automatic logic [31:0] absdiff(input logic signed [31:0] a,
                                           input logic signed [31:0] b);
      logic signed [31:0] d;
      d = a - b;
      return d[31] ? 32'(-d) : 32'(d);
   endfunction

   function automatic logic needs_loop(input logic signed [31:0] t, input logic on,
                                       input logic fwd, input logic signed [31:0] p);
      return on && (fwd ? (t < p) : (t > p));
   endfunction

   // A telegram's bits act at once; between telegrams the last one holds
   assign cur       = telegram_i ? cmd_i : st.cmd_last;
   assign idle      = (st.state == pdsc_pkg::S_IDLE);
   assign fault     = st.status[pdsc_pkg::ST_FAULT];
   assign vok       = (sense_i.motor_mv > sense_i.umin_mv) &&
                      (sense_i.motor_mv < pdsc_pkg::MOTOR_MAX_MV);
   assign loop_on   = (cfg_i.loop_len != 32'sh0) && !cur.no_loop;
   assign loop_fwd  = !cfg_i.loop_len[31];
   assign ack_rise  = telegram_i && cmd_i.err_ack && !st.cmd_last.err_ack;
   assign rel_rise  = telegram_i && cmd_i.release_run && !st.cmd_last.release_run;
   // speed word only on speed variants
   assign speed_bad = telegram_i && speed_in_pd_i && (target_speed_i > cfg_i.speed_max);
   assign tgt_ok    = (target_pos_i <= cfg_i.upper) && (target_pos_i >= cfg_i.lower) &&
                      !(needs_loop(target_pos_i, loop_on, loop_fwd, actual_pos_i) &&
                        (loop_fwd ? (target_pos_i - LOOP_STEPS < cfg_i.lower)
                                  : (target_pos_i + LOOP_STEPS > cfg_i.upper))) &&
                      !speed_bad;
   assign dev       = absdiff(actual_pos_i, st.target);
   // runs need release; no runs while faulted
   assign start_man = idle && telegram_i && cmd_i.release_run && !fault &&
                      (cmd_i.man_fwd || cmd_i.man_rev);
   // bit 2 takes target, release alone reuses last
   assign start_pos = idle && telegram_i && cmd_i.release_run && !fault &&
                      !cmd_i.man_fwd && !cmd_i.man_rev &&
                      (cmd_i.take_target ? tgt_ok : rel_rise);
   // turned out of window while standing
   assign displaced = idle && !telegram_i && st.completed && !running_i &&
                      (dev > $unsigned(cfg_i.window));
   assign readjust  = displaced && readjust_en_i && cur.release_run && !fault &&
                      (!loop_on || (loop_fwd ? (actual_pos_i < st.target)
                                             : (actual_pos_i > st.target)));
   assign go        = (start_pos || readjust) && vok;
   assign go_t      = (start_pos && cmd_i.take_target) ? target_pos_i : st.target;
   assign go_loop   = needs_loop(go_t, loop_on, loop_fwd, actual_pos_i);

   always_comb begin
      next_st = st;
      set_v   = 16'h0000;
      clr_v   = 16'h0000;
      if (telegram_i) begin
         next_st.cmd_last = cmd_i;
         next_st.param_set = cmd_i.param_set;
      end
      if (ack_rise) begin
         clr_v = clr_v | pdsc_pkg::ACK_CLEAR_MASK;
      end
      if (telegram_i && (cmd_i.take_target || speed_bad)) begin
         if (tgt_ok) begin
            clr_v[pdsc_pkg::ST_BADTGT] = 1'b1;
         end else begin
            set_v[pdsc_pkg::ST_BADTGT]  = 1'b1;
            clr_v[pdsc_pkg::ST_REACHED] = 1'b1;
         end
      end
      // targets are stored only at standstill
      if (idle && telegram_i && cmd_i.take_target && tgt_ok) begin
         next_st.target = target_pos_i;
      end
      case (st.state)
         pdsc_pkg::S_IDLE: begin
            if (start_man) begin
               next_st.state       = pdsc_pkg::S_MANUAL;
               next_st.move.req    = 1'b1;
               next_st.move.manual = 1'b1;
               next_st.move.fwd    = cmd_i.man_fwd;
               next_st.completed   = 1'b0;
               clr_v[pdsc_pkg::ST_REACHED] = 1'b1;
               clr_v[pdsc_pkg::ST_ABORT]   = 1'b1;
               if (cmd_i.man_fwd != loop_fwd) begin
                  set_v[pdsc_pkg::ST_OPPOSITE] = 1'b1;
               end
            end else if (start_pos || readjust) begin
               next_st.completed = 1'b0;
               if (start_pos) begin
                  clr_v[pdsc_pkg::ST_ABORT] = 1'b1;
                  clr_v[pdsc_pkg::ST_BLOCK] = 1'b1;
                  clr_v[pdsc_pkg::ST_DISPL] = 1'b1;
               end
               if (!vok) begin
                  set_v[pdsc_pkg::ST_NOPOWER] = 1'b1;
                  if (readjust) begin
                     set_v[pdsc_pkg::ST_BLOCK] = 1'b1;
                  end
               end else begin
                  clr_v[pdsc_pkg::ST_NOPOWER] = 1'b1;
               end
               if (absdiff(go_t, actual_pos_i) > $unsigned(cfg_i.window)) begin
                  clr_v[pdsc_pkg::ST_REACHED] = 1'b1;
               end
            end else if (displaced) begin
               next_st.completed = 1'b0;
               set_v[pdsc_pkg::ST_DISPL]   = 1'b1;
               clr_v[pdsc_pkg::ST_REACHED] = 1'b1;
            end
            if (go) begin
               next_st.second      = 1'b0;
               next_st.move.req    = 1'b1;
               next_st.move.manual = 1'b0;
               if (go_loop) begin
                  next_st.state     = pdsc_pkg::S_LOOP;
                  next_st.move.goal = loop_fwd ? go_t - LOOP_STEPS : go_t + LOOP_STEPS;
                  next_st.move.fwd  = !loop_fwd;
               end else begin
                  next_st.state     = pdsc_pkg::S_APPROACH;
                  next_st.move.goal = go_t;
                  next_st.move.fwd  = (go_t >= actual_pos_i);
               end
               if (go_loop || (loop_on && ((go_t >= actual_pos_i) != loop_fwd))) begin
                  set_v[pdsc_pkg::ST_OPPOSITE] = 1'b1;
               end
            end
         end
         pdsc_pkg::S_MANUAL: begin
            if ((telegram_i && !(cmd_i.release_run && (cmd_i.man_fwd || cmd_i.man_rev)))
                || !vok || (st.move.fwd ? (actual_pos_i >= cfg_i.upper)
                                        : (actual_pos_i <= cfg_i.lower))) begin
               next_st.state    = pdsc_pkg::S_IDLE;
               next_st.move.req = 1'b0;
            end
         end
         pdsc_pkg::S_LOOP, pdsc_pkg::S_APPROACH, pdsc_pkg::S_SECOND: begin
            if (telegram_i && !cmd_i.release_run) begin
               next_st.state    = pdsc_pkg::S_IDLE;
               next_st.move.req = 1'b0;
               set_v[pdsc_pkg::ST_ABORT] = 1'b1;
            end else if (overload_i || speed_bad) begin
               next_st.state    = pdsc_pkg::S_IDLE;
               next_st.move.req = 1'b0;
               set_v[pdsc_pkg::ST_BLOCK] = overload_i;
            end else if (!vok) begin
               next_st.state    = pdsc_pkg::S_IDLE;
               next_st.move.req = 1'b0;
               set_v[pdsc_pkg::ST_NOPOWER] = 1'b1;
            end else if (move_done_i) begin
               if (st.state == pdsc_pkg::S_LOOP) begin
                  next_st.state     = pdsc_pkg::S_APPROACH;
                  next_st.move.goal = st.target;
                  next_st.move.fwd  = loop_fwd;
               end else begin
                  next_st.state    = pdsc_pkg::S_CHECK;
                  next_st.move.req = 1'b0;
               end
            end
         end
         pdsc_pkg::S_CHECK: begin
            if ((dev > DEV_STEPS) && !st.second) begin
               next_st.state     = pdsc_pkg::S_SECOND;
               next_st.second    = 1'b1;
               next_st.move.req  = 1'b1;
               next_st.move.goal = st.target;
               next_st.move.fwd  = (st.target >= actual_pos_i);
            end else begin
               next_st.state     = pdsc_pkg::S_IDLE;
               next_st.completed = 1'b1;
               next_st.refloop   = 1'b0;
               if (dev > $unsigned(cfg_i.window)) begin
                  set_v[pdsc_pkg::ST_BLOCK]   = 1'b1;
                  clr_v[pdsc_pkg::ST_REACHED] = 1'b1;
               end else begin
                  set_v[pdsc_pkg::ST_REACHED] = 1'b1;
                  // arrival in loop direction or reference loop
                  if (st.move.fwd == loop_fwd || !loop_on || st.refloop) begin
                     clr_v[pdsc_pkg::ST_OPPOSITE] = 1'b1;
                  end
                  if (st.refloop) begin
                     clr_v[pdsc_pkg::ST_BLOCK] = 1'b1;
                     clr_v[pdsc_pkg::ST_DISPL] = 1'b1;
                  end
               end
            end
         end
         default: begin
            next_st.state    = pdsc_pkg::S_IDLE;
            next_st.move.req = 1'b0;
         end
      endcase
      // Set wins over clear so that no event is lost
      next_st.status = (st.status & ~clr_v) | set_v;
      if (telegram_i) begin
         next_st.status[pdsc_pkg::ST_TOGGLE] = cmd_i.toggle;
      end
      next_st.status[pdsc_pkg::ST_POWER]   = vok;
      next_st.status[pdsc_pkg::ST_RUNNING] = running_i;
      if (sense_i.temp_c > sense_i.temp_limit_c) begin
         next_st.status[pdsc_pkg::ST_TEMP] = 1'b1;
      end else if (sense_i.temp_c < sense_i.temp_limit_c - pdsc_pkg::TEMP_HYST_C) begin
         next_st.status[pdsc_pkg::ST_TEMP] = 1'b0;
      end
      if (flash_fault_i || calc_fault_i) begin
         next_st.status[pdsc_pkg::ST_FAULT] = 1'b1;
      end
      if ((actual_pos_i > cfg_i.upper) || (st.state == pdsc_pkg::S_MANUAL &&
          st.move.fwd && actual_pos_i >= cfg_i.upper)) begin
         next_st.status[pdsc_pkg::ST_LIM_FWD] = 1'b1;
      end else if (actual_pos_i < cfg_i.upper) begin
         next_st.status[pdsc_pkg::ST_LIM_FWD] = 1'b0;
      end
      if ((actual_pos_i < cfg_i.lower) || (st.state == pdsc_pkg::S_MANUAL &&
          !st.move.fwd && actual_pos_i <= cfg_i.lower)) begin
         next_st.status[pdsc_pkg::ST_LIM_REV] = 1'b1;
      end else if (actual_pos_i > cfg_i.lower) begin
         next_st.status[pdsc_pkg::ST_LIM_REV] = 1'b0;
      end
      next_st.rpm = actual_rpm_i;
      next_st.pos = actual_pos_i;
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i || (clk_en_i && reset_cmd_i)) begin
         st         <= '0;
         st.state   <= pdsc_pkg::S_IDLE;
         st.status  <= pdsc_pkg::STATUS_RESET;
         st.refloop <= 1'b1;
      end else if (clk_en_i) begin
         st <= next_st;
      end
   end

   assign status_word_o = st.status;
   // byte 0 is the most significant byte
   assign pd_in_o       = {st.status, st.rpm, st.pos};
   assign param_set_o   = st.param_set;
   assign move_o        = st.move;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   sequence check_far;
      clk_en_i && !reset_cmd_i && st.state == pdsc_pkg::S_CHECK &&
      dev > DEV_STEPS && !st.second;
   endsequence
   sequence loop_done;
      clk_en_i && !reset_cmd_i && st.state == pdsc_pkg::S_LOOP && move_done_i &&
      vok && !overload_i && !telegram_i;
   endsequence

   a_toggle_echo: assert property (clk_en_i && !reset_cmd_i && telegram_i |=>
      status_word_o[pdsc_pkg::ST_TOGGLE] == $past(cmd_i.toggle))
      else $error("toggle bit not echoed");
   a_release_abort: assert property (clk_en_i && !reset_cmd_i && telegram_i &&
      !cmd_i.release_run && (st.state & 6'h2C) != 6'h00 |=>
      st.state == pdsc_pkg::S_IDLE && status_word_o[pdsc_pkg::ST_ABORT] && !move_o.req)
      else $error("release loss did not abort");
   a_ack_clear: assert property (clk_en_i && !reset_cmd_i && ack_rise && idle &&
      !st.completed && !cmd_i.take_target && !cmd_i.release_run && !speed_bad |=>
      (status_word_o & pdsc_pkg::ACK_CLEAR_MASK) == 16'h0000)
      else $error("acknowledge did not clear errors");
   a_fault_blocks: assert property (idle && fault |=> idle)
      else $error("run started while faulted");
   a_temp_hold: assert property (clk_en_i && !reset_cmd_i &&
      status_word_o[pdsc_pkg::ST_TEMP] &&
      sense_i.temp_c >= sense_i.temp_limit_c - pdsc_pkg::TEMP_HYST_C |=>
      status_word_o[pdsc_pkg::ST_TEMP])
      else $error("temperature flag dropped inside hysteresis");
   a_second_once: assert property (check_far |=>
      st.state == pdsc_pkg::S_SECOND && move_o.goal == $past(st.target))
      else $error("second positioning missing");
   a_loop_approach: assert property (loop_done |=>
      st.state == pdsc_pkg::S_APPROACH && move_o.goal == st.target)
      else $error("loop not followed by approach");
   a_direct_run: assert property (clk_en_i && !reset_cmd_i && start_pos &&
      cmd_i.no_loop |=> st.state != pdsc_pkg::S_LOOP)
      else $error("loop run despite direct mode");
   a_target_hold: assert property (clk_en_i && telegram_i && !cmd_i.take_target &&
      !reset_cmd_i |=> $stable(st.target))
      else $error("target changed without transfer bit");
   a_opp_reset: assert property (clk_en_i && reset_cmd_i |=>
      status_word_o[pdsc_pkg::ST_OPPOSITE] && !status_word_o[pdsc_pkg::ST_FAULT])
      else $error("reset command did not restore status");
   a_nopower_start: assert property (clk_en_i && !reset_cmd_i && start_pos && !vok |=>
      status_word_o[pdsc_pkg::ST_NOPOWER] && idle)
      else $error("run started without motor power");
endmodule

// >>> tb/pdsc_motion_model.sv
`timescale 1ns/1ps
module pdsc_motion_model (
   input  wire logic                 clk_i,
   input  wire logic                 sys_rst_i,
   input  wire logic                 slow_i,
   input  wire pdsc_pkg::pdsc_move_t move_i,
   input  wire logic signed   [31:0] miss_i,
   output logic signed        [31:0] pos_o,
   output logic                      done_o
);
   logic [7:0] cnt;
   // Motion ends only after a delay, so aborts can land mid-run
   always_ff @(posedge clk_i) begin
      done_o <= 1'b0;
      if (sys_rst_i || !move_i.req) begin
         cnt <= 8'h00;
         if (sys_rst_i) begin
            pos_o <= 32'sh0;
         end
      end else if (cnt == (slow_i ? 8'hC8 : 8'h04)) begin
         cnt <= 8'h00;
         // Landing off the goal lets the bench provoke a second positioning
         pos_o <= move_i.goal + miss_i;
         done_o <= 1'b1;
      end else begin
         cnt <= cnt + 8'h01;
      end
   end
endmodule

// >>> tb/test_positioning_drive_status_control.sv
`timescale 1ns/1ps
module test_positioning_drive_status_control;
   logic clk_i = 1'b0, sys_rst_i = 1'b1, tel_i = 1'b0, slow = 1'b0, done;
   logic ovl = 1'b0, flash = 1'b0, rcmd = 1'b0;
   logic [15:0] cmd = 16'h0000, status;
   logic signed [31:0] tgt = 32'sh0, pos, t, miss = 32'sh0;
   logic [63:0] pd_in;
   logic [1:0] pset;
   logic [31:0] seed = 32'h00013FA4;
   pdsc_pkg::pdsc_move_t move;
   pdsc_pkg::pdsc_sense_t sense = '{16'h5DC0, 16'h4650, 16'sh0019, 16'sh0046};
   pdsc_pkg::pdsc_cfg_t cfg = '{32'sh3E8, -32'sh3E8, 32'sh2, 32'sh0, 16'hFFFF};
   int num_errors = 0, n_tests = 0;
   initial forever #2.5 clk_i = ~clk_i;
   pdsc_drive_ctrl pdsc_drive_ctrl_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .clk_en_i(1'b1), .telegram_i(tel_i), .cmd_i(cmd), .target_pos_i(tgt),
      .target_speed_i(16'h0000), .speed_in_pd_i(1'b0), .sense_i(sense), .cfg_i(cfg),
      .actual_pos_i(pos), .actual_rpm_i({15'h0000, move.req}), .running_i(move.req),
      .move_done_i(done), .overload_i(ovl), .flash_fault_i(flash),
      .calc_fault_i(1'b0), .reset_cmd_i(rcmd), .readjust_en_i(1'b0),
      .status_word_o(status), .pd_in_o(pd_in), .param_set_o(pset), .move_o(move));
   pdsc_motion_model pdsc_motion_model_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .slow_i(slow), .move_i(move), .miss_i(miss), .pos_o(pos), .done_o(done));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic pwr();
      return sense.motor_mv > sense.umin_mv && sense.motor_mv < pdsc_pkg::MOTOR_MAX_MV;
   endfunction
   function automatic logic signed [31:0] loop_steps();
      return 32'(pdsc_pkg::STEPS_PER_REV_DEF * pdsc_pkg::LOOP_NUM / pdsc_pkg::LOOP_DEN);
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tel(input logic [15:0] c, input logic signed [31:0] v);
      @(negedge clk_i);
      cmd = c;
      tgt = v;
      tel_i = 1'b1;
      @(negedge clk_i);
      tel_i = 1'b0;
      @(negedge clk_i);
   endtask
   task automatic wt(input int n);
      for (int i = 0; i < n && done !== 1'b1; i++) @(negedge clk_i);
      repeat (4) @(negedge clk_i);
   endtask
   task automatic results;
      $display("tests %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      // Whole run needs well under 10000 cycles
      #60us;
      num_errors++;
      results();
   end
   initial begin
      repeat (20) @(negedge clk_i);
      sys_rst_i = 1'b0;
      @(negedge clk_i);
      chk(status[8], 1'b1);
      chk(status[4], pwr());
      $display("reset test done");
      for (int i = 0; i < 8; i++) begin
         t = (xs() & 32'h00002000) | (i[1:0] << 8);
         tel(t[15:0], 32'sh0);
         chk(status[2], t[13]);
         chk(pset, t[9:8]);
      end
      $display("toggle test done");
      sense.motor_mv = 16'h7918;
      tel(16'h0014, 32'sh64);
      chk(status[4], pwr());
      chk(status[13], 1'b1);
      chk(move.req, 1'b0);
      sense.motor_mv = 16'h5DC0;
      tel(16'h0000, 32'sh0);
      t = (xs() & 32'h000001FF) + 32'sh1;
      tel(16'h0014, t);
      chk(status[13], 1'b0);
      wt(100);
      chk(status[0], 1'b1);
      chk(status[8], 1'b0);
      chk(pd_in[31:0], t);
      $display("run test done");
      slow = 1'b1;
      tel(16'h0000, 32'sh0);
      tel(16'h0004, t + 32'sh64);
      chk(move.req, 1'b0);
      tel(16'h0010, 32'sh0);
      chk(move.goal, t + 32'sh64);
      tel(16'h0000, 32'sh0);
      chk(status[5], 1'b1);
      chk(move.req, 1'b0);
      tel(16'h4000, 32'sh0);
      chk(status[5], 1'b0);
      $display("abort test done");
      tel(16'h0014, 32'sh7D0);
      chk(status[12], 1'b1);
      chk(status[0], 1'b0);
      tel(16'h0000, 32'sh0);
      tel(16'h0014, t);
      chk(status[12], 1'b0);
      @(negedge clk_i);
      ovl = 1'b1;
      @(negedge clk_i);
      ovl = 1'b0;
      repeat (3) @(negedge clk_i);
      chk(status[10], 1'b1);
      tel(16'h4000, 32'sh0);
      chk(status[10], 1'b0);
      $display("error test done");
      sense.temp_c = 16'sh0047;
      repeat (3) @(negedge clk_i);
      chk(status[7], 1'b1);
      sense.temp_c = 16'sh0043;
      repeat (3) @(negedge clk_i);
      chk(status[7], 1'b1);
      sense.temp_c = 16'sh0040;
      repeat (3) @(negedge clk_i);
      chk(status[7], 1'b0);
      flash = 1'b1;
      @(negedge clk_i);
      flash = 1'b0;
      tel(16'h0000, 32'sh0);
      tel(16'h0014, t + 32'sh5);
      chk(status[9], 1'b1);
      chk(move.req, 1'b0);
      rcmd = 1'b1;
      @(negedge clk_i);
      rcmd = 1'b0;
      repeat (3) @(negedge clk_i);
      chk(status[9], 1'b0);
      chk(status[8], 1'b1);
      $display("fault test done");
      slow = 1'b0;
      cfg.loop_len = 32'sh1;
      t = t - 32'sh12C;
      tel(16'h0014, t);
      chk(move.goal, t - loop_steps());
      chk(move.fwd, 1'b0);
      wt(100);
      wt(100);
      chk(status[0], 1'b1);
      chk(status[8], 1'b0);
      chk(pd_in[31:0], t);
      miss = 32'sh2;
      t = t - 32'sh12C;
      tel(16'h0054, t);
      chk(move.goal, t);
      wt(100);
      chk(move.req, 1'b1);
      chk(move.goal, t);
      wt(100);
      chk(status[0], 1'b1);
      chk(pd_in[31:0], t + 32'sh2);
      miss = 32'sh0;
      tel(16'h0014, 32'sh7D0);
      chk(status[0], 1'b0);
      cfg.upper = t;
      repeat (2) @(negedge clk_i);
      chk(status[14], 1'b1);
      cfg.upper = 32'sh3E8;
      repeat (2) @(negedge clk_i);
      chk(status[14], 1'b0);
      $display("loop test done");
      results();
   end
endmodule
